// ### hw/csm_pkg.sv
// constants shared by the core status and mode register block
// assumes nothing beyond a systemverilog compiler
package csm_pkg;
	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_PSTATUS = 8'h00;
	localparam logic [7:0] OFS_ILM = 8'h04;
	localparam logic [7:0] OFS_BUSMODE = 8'h08;
	localparam logic [7:0] OFS_MDH = 8'h0c;
	localparam logic [7:0] OFS_MDL = 8'h10;
	localparam logic [7:0] OFS_STRAP = 8'h14;
	localparam logic [7:0] OFS_SP = 8'h18;
	localparam logic [7:0] OFS_SSP = 8'h1c;
	localparam logic [7:0] OFS_USP = 8'h20;
	localparam logic [7:0] OFS_R13 = 8'h24;
	localparam logic [7:0] OFS_R14 = 8'h28;
	localparam logic [7:0] OFS_GPR_BASE = 8'h40;
	localparam logic [7:0] OFS_GPR_TOP = 8'h70;
	// processor status field positions
	localparam int PS_C = 0;
	localparam int PS_V = 1;
	localparam int PS_Z = 2;
	localparam int PS_N = 3;
	localparam int PS_I = 4;
	localparam int PS_S = 5;
	localparam int PS_T = 8;
	localparam int PS_ILM_LO = 16;
	localparam int ILM_W = 5;
	// bus mode field position inside bus_mode_config
	localparam int BM_LO = 6;
	// strap status field positions
	localparam int ST_CODE_LO = 0;
	localparam int ST_VEC_INT = 4;
	localparam int ST_BUS16 = 5;
	localparam int ST_BAD = 6;
	localparam int ST_BM_BAD = 7;
	// reset values
	localparam logic [31:0] SSP_RST = 32'h0000_0000;
	localparam logic [31:0] USP_RST = 32'h0000_0000;
	localparam logic [ILM_W-1:0] ILM_RST = 5'h1f;
	localparam logic [1:0] BM_RST = 2'h2;
	// direct addressing window limits per access width
	localparam logic [31:0] DIR_LIM_BYTE = 32'h0000_00ff;
	localparam logic [31:0] DIR_LIM_HALF = 32'h0000_01ff;
	localparam logic [31:0] DIR_LIM_WORD = 32'h0000_03ff;
	// access widths
	typedef enum logic [1:0] {
		CSM_SZ_BYTE = 2'b00,
		CSM_SZ_HALF = 2'b01,
		CSM_SZ_WORD = 2'b10
	} csm_size_e;
	// strap codes
	localparam logic [2:0] STRAP_EXT8 = 3'h0;
	localparam logic [2:0] STRAP_EXT16 = 3'h1;
	localparam logic [2:0] STRAP_INTVEC = 3'h3;
	// bus mode codes
	typedef enum logic [1:0] {
		CSM_BM_SINGLE = 2'b00,
		CSM_BM_INTROM = 2'b01,
		CSM_BM_EXTROM = 2'b10,
		CSM_BM_BAD = 2'b11
	} csm_bm_e;
endpackage

// ### hw/csm_gpr_mem.sv
// small general register store, write and read on the clock
// assumes one write port, one read port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module csm_gpr_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 13,
	parameter int AW = 4
) (
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem [DEPTH];
	// no reset: contents are undefined after reset
	always_ff @(posedge i_clk) begin
		if (i_we && (int'(i_waddr) < DEPTH)) begin
			mem[i_waddr] <= i_wdata;
		end
		if (int'(i_raddr) < DEPTH) begin
			o_rdata <= mem[i_raddr];
		end else begin
			o_rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// ### hw/csm_flag_calc.sv
// add or subtract with carry and signed overflow outputs
// assumes operands are plain two's complement words
`timescale 1ns/1ps
`default_nettype none
module csm_flag_calc #(
	parameter int W = 32
) (
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	input wire logic i_sub,
	output logic [W-1:0] o_res,
	output logic o_carry,
	output logic o_ovf
);
	logic [W:0] sum;
	logic [W-1:0] b_eff;
	always_comb begin
		b_eff = i_sub ? ~i_b : i_b;
		sum = {1'b0, i_a} + {1'b0, b_eff} + {{W{1'b0}}, i_sub};
		o_res = sum[W-1:0];
		// carry out on add, borrow out on subtract
		o_carry = i_sub ? ~sum[W] : sum[W];
		o_ovf = (i_a[W-1] == b_eff[W-1]) && (sum[W-1] != i_a[W-1]);
	end
endmodule
`default_nettype wire

// ### hw/csm_core_regs.sv
// core status word, stack pointers, result pair, general registers and mode decode
// assumes a one-clock register port with read data one cycle after the strobe
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csm_core_regs #(
	parameter int DW = 32,
	parameter int GPR_DEPTH = 13
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// strap pins
	input wire logic i_boot_strap_hi,
	input wire logic i_boot_strap_mid,
	input wire logic i_boot_strap_lo,
	// arithmetic flag update
	input wire logic i_alu_upd,
	input wire logic [31:0] i_alu_a,
	input wire logic [31:0] i_alu_b,
	input wire logic i_alu_sub,
	output logic [31:0] o_alu_res,
	// division result flag update and result pair load
	input wire logic i_div_upd,
	input wire logic [31:0] i_div_res,
	input wire logic i_md_load,
	input wire logic [31:0] i_md_hi,
	input wire logic [31:0] i_md_lo,
	// interrupt request
	input wire logic i_irq_req,
	input wire logic [4:0] i_irq_level,
	output logic o_irq_accept,
	// step trace
	input wire logic i_insn_done,
	output logic o_trace_trap,
	// direct address window
	input wire logic [31:0] i_dir_addr,
	input wire logic [1:0] i_dir_size,
	output logic o_dir_ok,
	// role registers and modes
	output logic [31:0] o_stack_ptr,
	output logic [31:0] o_r13_sum_reg,
	output logic [31:0] o_frame_base_reg,
	output logic [31:0] o_muldiv_high,
	output logic [31:0] o_muldiv_low,
	output logic [31:0] o_processor_status,
	output logic [1:0] o_bus_mode,
	output logic o_bus_mode_bad,
	output logic o_vec_internal,
	output logic o_bus16,
	output logic o_strap_bad
);
	typedef struct packed {
		logic flag_s;
		logic flag_i;
		logic flag_n;
		logic flag_z;
		logic flag_v;
		logic flag_c;
		logic flag_t;
		logic [csm_pkg::ILM_W-1:0] interrupt_level_mask;
		logic [31:0] muldiv_high;
		logic [31:0] muldiv_low;
		logic [31:0] system_stack_ptr;
		logic [31:0] user_stack_ptr;
		logic [31:0] r13;
		logic [31:0] r14;
		logic [1:0] bus_mode;
		logic strap_taken;
		logic [2:0] strap;
		logic [31:0] rdata;
		logic rd_gpr;
		logic trace;
		logic [31:0] alu_res;
	} csm_state_s;

	csm_state_s st_ff;
	csm_state_s nxt_st;

	logic [31:0] calc_res;
	logic calc_c;
	logic calc_v;
	logic [31:0] ps_word;
	logic [31:0] sp_cur;
	logic [31:0] strap_word;
	logic gpr_hit;
	logic gpr_we;
	logic [3:0] gpr_idx;
	logic [31:0] gpr_rdata;
	logic [31:0] dir_lim;
	logic [7:0] gpr_off;

	csm_flag_calc #(
		.W(32)
	) u_calc (
		.i_a(i_alu_a),
		.i_b(i_alu_b),
		.i_sub(i_alu_sub),
		.o_res(calc_res),
		.o_carry(calc_c),
		.o_ovf(calc_v)
	);

	// registers 0 to 12 live in the store; 13 and 14 sit beside the logic
	always_comb begin
		gpr_off = i_addr - csm_pkg::OFS_GPR_BASE;
		gpr_hit = (i_addr >= csm_pkg::OFS_GPR_BASE) && (i_addr <= csm_pkg::OFS_GPR_TOP)
			&& (i_addr[1:0] == 2'h0);
		gpr_idx = gpr_off[5:2];
		gpr_we = i_wr && gpr_hit;
	end

	csm_gpr_mem #(
		.WIDTH(32),
		.DEPTH(GPR_DEPTH),
		.AW(4)
	) u_gpr (
		.i_clk(i_clk),
		.i_we(gpr_we),
		.i_waddr(gpr_idx),
		.i_wdata(i_wdata),
		.i_raddr(gpr_idx),
		.o_rdata(gpr_rdata)
	);

	always_comb begin
		// status word packs the three groups
		ps_word = '0;
		ps_word[csm_pkg::PS_C] = st_ff.flag_c;
		ps_word[csm_pkg::PS_V] = st_ff.flag_v;
		ps_word[csm_pkg::PS_Z] = st_ff.flag_z;
		ps_word[csm_pkg::PS_N] = st_ff.flag_n;
		ps_word[csm_pkg::PS_I] = st_ff.flag_i;
		ps_word[csm_pkg::PS_S] = st_ff.flag_s;
		ps_word[csm_pkg::PS_T] = st_ff.flag_t;
		ps_word[csm_pkg::PS_ILM_LO +: csm_pkg::ILM_W] = st_ff.interrupt_level_mask;
		// register 15 view follows the stack select flag
		sp_cur = st_ff.flag_s ? st_ff.user_stack_ptr : st_ff.system_stack_ptr;
		strap_word = '0;
		strap_word[csm_pkg::ST_CODE_LO +: 3] = st_ff.strap;
		strap_word[csm_pkg::ST_VEC_INT] = o_vec_internal;
		strap_word[csm_pkg::ST_BUS16] = o_bus16;
		strap_word[csm_pkg::ST_BAD] = o_strap_bad;
		strap_word[csm_pkg::ST_BM_BAD] = o_bus_mode_bad;
	end

	// strap decode from the held copy
	always_comb begin
		o_vec_internal = 1'b0;
		o_bus16 = 1'b0;
		o_strap_bad = 1'b0;
		case (st_ff.strap)
			csm_pkg::STRAP_EXT8: begin
				o_bus16 = 1'b0;
			end
			csm_pkg::STRAP_EXT16: begin
				o_bus16 = 1'b1;
			end
			csm_pkg::STRAP_INTVEC: begin
				o_vec_internal = 1'b1;
			end
			default: begin
				o_strap_bad = 1'b1;
			end
		endcase
	end

	// bus mode decode
	always_comb begin
		o_bus_mode = st_ff.bus_mode;
		case (st_ff.bus_mode)
			csm_pkg::CSM_BM_SINGLE: o_bus_mode_bad = 1'b0;
			csm_pkg::CSM_BM_INTROM: o_bus_mode_bad = 1'b0;
			csm_pkg::CSM_BM_EXTROM: o_bus_mode_bad = 1'b0;
			default: o_bus_mode_bad = 1'b1;
		endcase
	end

	// direct addressing window check
	always_comb begin
		case (i_dir_size)
			csm_pkg::CSM_SZ_BYTE: dir_lim = csm_pkg::DIR_LIM_BYTE;
			csm_pkg::CSM_SZ_HALF: dir_lim = csm_pkg::DIR_LIM_HALF;
			csm_pkg::CSM_SZ_WORD: dir_lim = csm_pkg::DIR_LIM_WORD;
			default: dir_lim = '0;
		endcase
		// full 32-bit compare, no bank or segment bits
		o_dir_ok = (i_dir_size != 2'h3) && (i_dir_addr <= dir_lim);
	end

	// interrupt acceptance: strictly lower level number than the mask
	always_comb begin
		o_irq_accept = i_irq_req && st_ff.flag_i
			&& (i_irq_level < st_ff.interrupt_level_mask);
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.trace = 1'b0;
		// catch straps once, on the first edge after reset release
		if (!st_ff.strap_taken) begin
			nxt_st.strap = {i_boot_strap_hi, i_boot_strap_mid, i_boot_strap_lo};
			nxt_st.strap_taken = 1'b1;
		end
		// software writes
		if (i_wr) begin
			case (i_addr)
				csm_pkg::OFS_PSTATUS: begin
					nxt_st.flag_c = i_wdata[csm_pkg::PS_C];
					nxt_st.flag_v = i_wdata[csm_pkg::PS_V];
					nxt_st.flag_z = i_wdata[csm_pkg::PS_Z];
					nxt_st.flag_n = i_wdata[csm_pkg::PS_N];
					nxt_st.flag_i = i_wdata[csm_pkg::PS_I];
					nxt_st.flag_s = i_wdata[csm_pkg::PS_S];
					nxt_st.flag_t = i_wdata[csm_pkg::PS_T];
					nxt_st.interrupt_level_mask = i_wdata[csm_pkg::PS_ILM_LO +: csm_pkg::ILM_W];
				end
				csm_pkg::OFS_ILM: begin
					nxt_st.interrupt_level_mask = i_wdata[csm_pkg::ILM_W-1:0];
				end
				csm_pkg::OFS_BUSMODE: begin
					// 00, 01 and 10 are meaningful; 11 is stored and flagged
					nxt_st.bus_mode = i_wdata[csm_pkg::BM_LO +: 2];
				end
				csm_pkg::OFS_MDH: begin
					nxt_st.muldiv_high = i_wdata;
				end
				csm_pkg::OFS_MDL: begin
					nxt_st.muldiv_low = i_wdata;
				end
				csm_pkg::OFS_SP: begin
					if (st_ff.flag_s) begin
						nxt_st.user_stack_ptr = i_wdata;
					end else begin
						nxt_st.system_stack_ptr = i_wdata;
					end
				end
				csm_pkg::OFS_SSP: begin
					nxt_st.system_stack_ptr = i_wdata;
				end
				csm_pkg::OFS_USP: begin
					nxt_st.user_stack_ptr = i_wdata;
				end
				csm_pkg::OFS_R13: begin
					nxt_st.r13 = i_wdata;
				end
				csm_pkg::OFS_R14: begin
					nxt_st.r14 = i_wdata;
				end
				default: begin
					nxt_st.rd_gpr = st_ff.rd_gpr;
				end
			endcase
		end
		// hardware flag updates take priority over a software write
		if (i_alu_upd) begin
			nxt_st.flag_c = calc_c;
			nxt_st.flag_v = calc_v;
			nxt_st.alu_res = calc_res;
		end
		if (i_div_upd) begin
			nxt_st.flag_n = i_div_res[31];
			nxt_st.flag_z = (i_div_res == 32'h0000_0000);
		end
		if (i_md_load) begin
			nxt_st.muldiv_high = i_md_hi;
			nxt_st.muldiv_low = i_md_lo;
		end
		// one-cycle trap after an instruction while trace is on
		nxt_st.trace = i_insn_done && st_ff.flag_t;
		// register reads, data in the next cycle
		nxt_st.rd_gpr = i_rd && gpr_hit;
		if (i_rd) begin
			case (i_addr)
				csm_pkg::OFS_PSTATUS: nxt_st.rdata = ps_word;
				csm_pkg::OFS_ILM: nxt_st.rdata = {27'h0, st_ff.interrupt_level_mask};
				csm_pkg::OFS_MDH: nxt_st.rdata = st_ff.muldiv_high;
				csm_pkg::OFS_MDL: nxt_st.rdata = st_ff.muldiv_low;
				csm_pkg::OFS_STRAP: nxt_st.rdata = strap_word;
				csm_pkg::OFS_SP: nxt_st.rdata = sp_cur;
				csm_pkg::OFS_SSP: nxt_st.rdata = st_ff.system_stack_ptr;
				csm_pkg::OFS_USP: nxt_st.rdata = st_ff.user_stack_ptr;
				csm_pkg::OFS_R13: nxt_st.rdata = st_ff.r13;
				csm_pkg::OFS_R14: nxt_st.rdata = st_ff.r14;
				// bus mode register is write-only and reads as zero
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end else begin
			nxt_st.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff.flag_s <= 1'b0;
			st_ff.flag_i <= 1'b0;
			st_ff.flag_n <= 1'b0;
			st_ff.flag_z <= 1'b0;
			st_ff.flag_v <= 1'b0;
			st_ff.flag_c <= 1'b0;
			st_ff.flag_t <= 1'b0;
			st_ff.interrupt_level_mask <= csm_pkg::ILM_RST;
			st_ff.muldiv_high <= 32'h0000_0000;
			st_ff.muldiv_low <= 32'h0000_0000;
			// system stack pointer cleared, so register 15 reads zero
			st_ff.system_stack_ptr <= csm_pkg::SSP_RST;
			st_ff.user_stack_ptr <= csm_pkg::USP_RST;
			st_ff.r13 <= 32'h0000_0000;
			st_ff.r14 <= 32'h0000_0000;
			st_ff.bus_mode <= csm_pkg::BM_RST;
			st_ff.strap_taken <= 1'b0;
			st_ff.strap <= 3'h0;
			st_ff.rdata <= 32'h0000_0000;
			st_ff.rd_gpr <= 1'b0;
			st_ff.trace <= 1'b0;
			st_ff.alu_res <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// general register data come straight from the store's output register
	assign o_rdata = st_ff.rd_gpr ? gpr_rdata : st_ff.rdata;
	assign o_trace_trap = st_ff.trace;
	assign o_alu_res = st_ff.alu_res;
	assign o_stack_ptr = sp_cur;
	assign o_r13_sum_reg = st_ff.r13;
	assign o_frame_base_reg = st_ff.r14;
	assign o_muldiv_high = st_ff.muldiv_high;
	assign o_muldiv_low = st_ff.muldiv_low;
	assign o_processor_status = ps_word;
endmodule
`default_nettype wire

// ### dv/csm_core_regs_properties.sv
// port checker for the core status and mode block
// assumes binding onto csm_core_regs, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module csm_core_regs_properties (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_boot_strap_hi,
	input wire logic i_boot_strap_mid,
	input wire logic i_boot_strap_lo,
	input wire logic i_alu_upd,
	input wire logic [31:0] i_alu_a,
	input wire logic [31:0] i_alu_b,
	input wire logic i_alu_sub,
	input wire logic i_div_upd,
	input wire logic [31:0] i_div_res,
	input wire logic i_md_load,
	input wire logic [31:0] i_md_hi,
	input wire logic [31:0] i_md_lo,
	input wire logic i_irq_req,
	input wire logic [4:0] i_irq_level,
	input wire logic o_irq_accept,
	input wire logic i_insn_done,
	input wire logic o_trace_trap,
	input wire logic [31:0] i_dir_addr,
	input wire logic [1:0] i_dir_size,
	input wire logic o_dir_ok,
	input wire logic [31:0] o_muldiv_high,
	input wire logic [31:0] o_muldiv_low,
	input wire logic [31:0] o_processor_status,
	input wire logic [1:0] o_bus_mode,
	input wire logic o_bus_mode_bad,
	input wire logic o_vec_internal,
	input wire logic o_bus16,
	input wire logic o_strap_bad
);
	logic [1:0] arm_ff;
	logic [32:0] sum;
	logic [32:0] dif;
	logic [2:0] code;
	logic c_exp;
	logic v_exp;
	assign sum = {1'b0, i_alu_a} + {1'b0, i_alu_b};
	assign dif = {1'b0, i_alu_a} - {1'b0, i_alu_b};
	assign code = {i_boot_strap_hi, i_boot_strap_mid, i_boot_strap_lo};
	assign c_exp = i_alu_sub ? dif[32] : sum[32];
	assign v_exp = i_alu_sub ? (i_alu_a[31] != i_alu_b[31]) && (dif[31] != i_alu_a[31]) :
		(i_alu_a[31] == i_alu_b[31]) && (sum[31] != i_alu_a[31]);
	// counts edges since reset release, saturating
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			arm_ff <= 2'h0;
		end else if (arm_ff != 2'h3) begin
			arm_ff <= arm_ff + 2'h1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_trace_req;
		i_insn_done && o_processor_status[8];
	endsequence
	sequence s_trace_trap;
		(o_trace_trap ##1 !o_trace_trap) or (o_trace_trap and s_trace_req);
	endsequence
	AST_TRACE_ON: assert property (s_trace_req |=> s_trace_trap)
		else $error("trace trap missing");
	AST_TRACE_OFF: assert property (o_trace_trap |-> $past(i_insn_done && o_processor_status[8]))
		else $error("trace trap without cause");
	AST_IRQ_OFF: assert property (!o_processor_status[4] |-> !o_irq_accept)
		else $error("irq accepted while disabled");
	AST_IRQ_LVL: assert property (i_irq_req && o_processor_status[4] |-> o_irq_accept == (i_irq_level < o_processor_status[20:16]))
		else $error("irq level compare wrong");
	AST_DIR: assert property (o_dir_ok == (i_dir_size == 2'h0 ? i_dir_addr <= csm_pkg::DIR_LIM_BYTE :
		i_dir_size == 2'h1 ? i_dir_addr <= csm_pkg::DIR_LIM_HALF :
		i_dir_size == 2'h2 ? i_dir_addr <= csm_pkg::DIR_LIM_WORD : 1'b0))
		else $error("direct window wrong");
	AST_ALU_C: assert property (i_alu_upd |=> o_processor_status[0] == $past(c_exp))
		else $error("carry flag wrong");
	AST_ALU_V: assert property (i_alu_upd |=> o_processor_status[1] == $past(v_exp))
		else $error("overflow flag wrong");
	AST_DIV: assert property (i_div_upd |=> o_processor_status[3:2] == $past({i_div_res[31], i_div_res == 32'h0}))
		else $error("sign or zero flag wrong");
	AST_MD: assert property (i_md_load |=> {o_muldiv_high, o_muldiv_low} == $past({i_md_hi, i_md_lo}))
		else $error("result pair load wrong");
	AST_STRAP_DEC: assert property (arm_ff == 2'h1 |-> {o_vec_internal, o_bus16, o_strap_bad} == $past({code == 3'h3, code == 3'h1, code == 3'h2 || code[2]}))
		else $error("strap decode wrong");
	AST_STRAP_HOLD: assert property (arm_ff == 2'h3 |-> $stable({o_vec_internal, o_bus16, o_strap_bad}))
		else $error("strap mode changed after reset");
	AST_BM_BAD: assert property (o_bus_mode_bad == (o_bus_mode == 2'h3))
		else $error("bus mode bad flag wrong");
endmodule
bind csm_core_regs csm_core_regs_properties csm_core_regs_properties_i (.*);
`default_nettype wire

// ### dv/tb_csm_core_regs.sv
// self-checking bench for the core status and mode block
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
`default_nettype none
module tb_csm_core_regs;
	logic i_clk, i_rstn, i_wr, i_rd, i_alu_upd, i_alu_sub, i_div_upd, i_md_load;
	logic i_boot_strap_hi, i_boot_strap_mid, i_boot_strap_lo, i_irq_req, i_insn_done;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, i_alu_a, i_alu_b, i_div_res, i_md_hi, i_md_lo, i_dir_addr;
	logic [4:0] i_irq_level;
	logic [1:0] i_dir_size, o_bus_mode;
	logic [31:0] o_rdata, o_alu_res, o_stack_ptr, o_r13_sum_reg, o_frame_base_reg;
	logic [31:0] o_muldiv_high, o_muldiv_low, o_processor_status;
	logic o_irq_accept, o_trace_trap, o_dir_ok, o_bus_mode_bad, o_vec_internal, o_bus16;
	logic o_strap_bad;
	int errors, check_count;
	csm_core_regs csm_core_regs_i (.*);
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk("rdata", e, o_rdata);
	endtask
	task automatic do_reset(input logic [2:0] s);
		i_rstn <= 1'b0;
		{i_boot_strap_hi, i_boot_strap_mid, i_boot_strap_lo} <= s;
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic t_reset_vals();
		rd(csm_pkg::OFS_PSTATUS, 32'h001f_0000);
		rd(csm_pkg::OFS_SP, csm_pkg::SSP_RST);
		rd(csm_pkg::OFS_BUSMODE, 32'h0);
		rd(8'h3c, 32'h0);
		chk("bus_mode", 32'h2, o_bus_mode);
	endtask
	task automatic t_straps();
		logic [2:0] c;
		logic [2:0] e;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			e = {c == 3'h3, c == 3'h1, c == 3'h2 || c[2]};
			do_reset(c);
			chk("strap", e, {o_vec_internal, o_bus16, o_strap_bad});
			rd(csm_pkg::OFS_STRAP, {25'h0, e[0], e[1], e[2], 1'b0, c});
			@(posedge i_clk);
			{i_boot_strap_hi, i_boot_strap_mid, i_boot_strap_lo} <= ~c;
			repeat (3) @(posedge i_clk);
			#1;
			chk("strap held", e, {o_vec_internal, o_bus16, o_strap_bad});
		end
	endtask
	task automatic t_irq();
		wr(csm_pkg::OFS_PSTATUS, 32'h10);
		wr(csm_pkg::OFS_ILM, 32'hf);
		rd(csm_pkg::OFS_PSTATUS, 32'h000f_0010);
		for (int lv = 14; lv < 17; lv++) begin
			@(posedge i_clk);
			i_irq_req <= 1'b1;
			i_irq_level <= lv[4:0];
			@(posedge i_clk);
			#1;
			chk("irq accept", 32'(lv < 15), o_irq_accept);
		end
		wr(csm_pkg::OFS_PSTATUS, 32'h0);
		i_irq_level <= 5'h0;
		@(posedge i_clk);
		#1;
		chk("irq held off", 32'h0, o_irq_accept);
		i_irq_req <= 1'b0;
	endtask
	task automatic t_trace(input logic t);
		wr(csm_pkg::OFS_PSTATUS, {23'h0, t, 8'h0});
		@(posedge i_clk);
		i_insn_done <= 1'b1;
		@(posedge i_clk);
		i_insn_done <= 1'b0;
		#1;
		chk("trap", 32'(t), o_trace_trap);
		@(posedge i_clk);
		#1;
		chk("trap end", 32'h0, o_trace_trap);
	endtask
	task automatic t_alu();
		logic [31:0] a[5] = '{32'hffff_ffff, 32'h7fff_ffff, 32'h0, 32'h8000_0000, 32'h5};
		logic [4:0] s = 5'b11100;
		logic [1:0] cv[5] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b00};
		for (int i = 0; i < 5; i++) begin
			@(posedge i_clk);
			i_alu_a <= a[i];
			i_alu_b <= (i == 4) ? 32'h3 : 32'h1;
			i_alu_sub <= s[i];
			i_alu_upd <= 1'b1;
			@(posedge i_clk);
			i_alu_upd <= 1'b0;
			#1;
			chk("carry ovf", cv[i], {o_processor_status[0], o_processor_status[1]});
			chk("alu res", s[i] ? a[i] - ((i == 4) ? 32'h3 : 32'h1) : a[i] + 32'h1, o_alu_res);
		end
	endtask
	task automatic t_div();
		for (int i = 0; i < 2; i++) begin
			@(posedge i_clk);
			i_div_res <= i ? 32'h0 : 32'h8000_0000;
			i_div_upd <= 1'b1;
			@(posedge i_clk);
			i_div_upd <= 1'b0;
			#1;
			chk("neg zero", i ? 32'h1 : 32'h2, o_processor_status[3:2]);
		end
	endtask
	task automatic t_md();
		@(posedge i_clk);
		i_md_hi <= 32'ha5a5_0001;
		i_md_lo <= 32'h5a5a_0002;
		i_md_load <= 1'b1;
		@(posedge i_clk);
		i_md_load <= 1'b0;
		#1;
		chk("md high", 32'ha5a5_0001, o_muldiv_high);
		chk("md low", 32'h5a5a_0002, o_muldiv_low);
		wr(csm_pkg::OFS_MDL, 32'h1234_5678);
		rd(csm_pkg::OFS_MDL, 32'h1234_5678);
		wr(csm_pkg::OFS_GPR_BASE, 32'h0bad_f00d);
		rd(csm_pkg::OFS_GPR_BASE, 32'h0bad_f00d);
	endtask
	task automatic t_stack();
		wr(csm_pkg::OFS_PSTATUS, 32'h20);
		wr(csm_pkg::OFS_SP, 32'h0000_8000);
		chk("user sp", 32'h0000_8000, o_stack_ptr);
		rd(csm_pkg::OFS_SSP, 32'h0);
		wr(csm_pkg::OFS_PSTATUS, 32'h0);
		chk("system sp", 32'h0, o_stack_ptr);
		wr(csm_pkg::OFS_R13, 32'hc0de_0013);
		wr(csm_pkg::OFS_R14, 32'hc0de_0014);
		chk("r13", 32'hc0de_0013, o_r13_sum_reg);
		chk("r14", 32'hc0de_0014, o_frame_base_reg);
	endtask
	task automatic t_dir();
		logic [31:0] ad[8] = '{32'hff, 32'h100, 32'h1ff, 32'h200, 32'h3ff, 32'h400, 32'h0,
			32'h1000_00ff};
		logic [1:0] sz[8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clk);
			i_dir_addr <= ad[i];
			i_dir_size <= sz[i];
			@(posedge i_clk);
			#1;
			chk("dir ok", 32'(i < 6 && i % 2 == 0), o_dir_ok);
		end
	endtask
	task automatic t_bm();
		for (int m = 0; m < 4; m++) begin
			wr(csm_pkg::OFS_BUSMODE, 32'(m) << csm_pkg::BM_LO);
			chk("bus mode", 32'(m), o_bus_mode);
			chk("bus mode bad", 32'(m == 3), o_bus_mode_bad);
		end
		wr(csm_pkg::OFS_BUSMODE, 32'h80);
		chk("bus mode", 32'h2, o_bus_mode);
		rd(csm_pkg::OFS_BUSMODE, 32'h0);
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		errors++;
		results();
	end
	initial begin
		{i_rstn, i_wr, i_rd, i_alu_upd, i_alu_sub, i_div_upd, i_md_load, i_irq_req} = 8'h0;
		{i_boot_strap_hi, i_boot_strap_mid, i_boot_strap_lo, i_insn_done} = 4'h0;
		{i_addr, i_wdata, i_alu_a, i_alu_b, i_div_res, i_md_hi, i_md_lo} = '0;
		{i_dir_addr, i_irq_level, i_dir_size} = '0;
		do_reset(3'h1);
		t_reset_vals();
		t_straps();
		do_reset(3'h1);
		t_irq();
		t_trace(1'b1);
		t_trace(1'b0);
		t_alu();
		t_div();
		t_md();
		t_stack();
		t_dir();
		t_bm();
		results();
	end
endmodule
`default_nettype wire
